// File: src/led_scan_pkg.sv
// shared constants, types and helpers of the led decode and scan core
package led_scan_pkg;

	// clock rate and scan timing
	localparam int CLK_MHZ = 250;
	localparam int TICK_US = 1;
	localparam int TICK_CYCLES = CLK_MHZ * TICK_US;
	localparam int DIGIT_ON_US = 320;
	localparam int GAP_US = 10;
	localparam int GAP_MIN_US = 2;
	localparam int DIGIT_ON_TICKS = DIGIT_ON_US / TICK_US;
	localparam int GAP_TICKS = GAP_US / TICK_US;
	localparam int NUM_DIGITS = 8;

	// control word fields
	localparam int CW_ADDR_LSB = 0;
	localparam int CW_BANK = 3;
	localparam int CW_RUN = 4;
	localparam int CW_DECODE = 5;
	localparam int CW_HEX = 6;
	localparam int CW_DATA_COMING = 7;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// data word fields
	localparam int DATA_DP = 7;
	localparam int SEG_DP = 7;

	// display ram word: raw flag, decoded dp, bank b, bank a
	localparam int RAM_W = 10;
	localparam int RAM_RAW = 9;
	localparam int RAM_DP = 8;
	localparam logic [9:0] MASK_BANK_A = 10'h30f;
	localparam logic [9:0] MASK_BANK_B = 10'h3f0;
	localparam logic [9:0] MASK_RAW = 10'h2ff;

	// three level select input encoding
	localparam logic [1:0] FSS_HIGH = 2'h3;
	localparam logic [1:0] FSS_MID = 2'h1;
	localparam logic [1:0] FSS_LOW = 2'h0;

	typedef enum logic [1:0] {
		FMT_HEX = 2'h0,
		FMT_CODEB = 2'h1,
		FMT_RAW = 2'h3
	} fmt_type;

	typedef enum logic {
		SCAN_GAP = 1'b0,
		SCAN_ON = 1'b1
	} scan_state_type;

	// zero based digit index driven in each scan slot
	function automatic logic [2:0] digit_of_slot(input logic [2:0] slot);
		logic [2:0] d;
		d = 3'h0;
		unique case (slot)
			3'h0: d = 3'h1;
			3'h1: d = 3'h4;
			3'h2: d = 3'h0;
			3'h3: d = 3'h6;
			3'h4: d = 3'h7;
			3'h5: d = 3'h5;
			3'h6: d = 3'h3;
			3'h7: d = 3'h2;
		endcase
		return d;
	endfunction

endpackage

// File: src/led_digit_ram.sv
// eight word display ram with masked write and registered read
`timescale 1ns/1ns
module led_digit_ram #(
	parameter int DEPTH = 8,
	parameter int WIDTH = 10
)
(
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_wr_en,
	input wire logic [2:0] i_wr_addr,
	input wire logic [WIDTH-1:0] i_wr_data,
	input wire logic [WIDTH-1:0] i_wr_mask,
	input wire logic [2:0] i_rd_addr,
	output logic [WIDTH-1:0] o_rd_data
);
	logic [WIDTH-1:0] mem [DEPTH];

	// cleared by reset only, so contents survive shutdown
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			mem <= '{default: '0};
		end
		else if (i_wr_en)
		begin
			mem[i_wr_addr] <= (mem[i_wr_addr] & ~i_wr_mask)
				| (i_wr_data & i_wr_mask);
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_rd_data <= '0;
		end
		else
		begin
			o_rd_data <= mem[i_rd_addr];
		end
	end
endmodule

// File: src/led_seg_decode.sv
// seven segment decoder for hex, alternate set and direct formats
`timescale 1ns/1ns
module led_seg_decode (
	input wire led_scan_pkg::fmt_type i_fmt,
	input wire logic [3:0] i_code,
	input wire logic [7:0] i_raw,
	input wire logic i_dp,
	output logic [7:0] o_seg
);
	import led_scan_pkg::*;

	// segment order g f e d c b a, one lights
	function automatic logic [6:0] seg_hex(input logic [3:0] c);
		logic [6:0] s;
		s = 7'h00;
		unique case (c)
			4'h0: s = 7'h3f;
			4'h1: s = 7'h06;
			4'h2: s = 7'h5b;
			4'h3: s = 7'h4f;
			4'h4: s = 7'h66;
			4'h5: s = 7'h6d;
			4'h6: s = 7'h7d;
			4'h7: s = 7'h07;
			4'h8: s = 7'h7f;
			4'h9: s = 7'h6f;
			4'ha: s = 7'h77;
			4'hb: s = 7'h7c;
			4'hc: s = 7'h39;
			4'hd: s = 7'h5e;
			4'he: s = 7'h79;
			4'hf: s = 7'h71;
		endcase
		return s;
	endfunction

	function automatic logic [6:0] seg_codeb(input logic [3:0] c);
		logic [6:0] s;
		s = 7'h00;
		unique case (c)
			4'ha: s = 7'h40;
			4'hb: s = 7'h79;
			4'hc: s = 7'h76;
			4'hd: s = 7'h38;
			4'he: s = 7'h73;
			4'hf: s = 7'h00;
			default: s = seg_hex(c);
		endcase
		return s;
	endfunction

	always_comb
	begin
		unique case (i_fmt)
			// bits 6..0 drive a b c e g f d, dp lit by a zero
			FMT_RAW: o_seg = {~i_raw[7], i_raw[2], i_raw[1], i_raw[3],
				i_raw[0], i_raw[4], i_raw[5], i_raw[6]};
			// decoded dp also lit by a zero, so an all ones word is dark in the alternate set, not in hex
			FMT_HEX: o_seg = {~i_dp, seg_hex(i_code)};
			FMT_CODEB: o_seg = {~i_dp, seg_codeb(i_code)};
			default: o_seg = 8'h00;
		endcase
	end
endmodule

// File: src/led_scan_core.sv
// led display decode, data entry and multiplex scan core
`timescale 1ns/1ns
module led_scan_core #(
	parameter bit PARALLEL_VARIANT = 1'b0,
	parameter int TICK_LEN = led_scan_pkg::TICK_CYCLES,
	parameter int GAP_LEN = led_scan_pkg::GAP_TICKS,
	parameter int ON_LEN = led_scan_pkg::DIGIT_ON_TICKS
)
(
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_write_n,
	input wire logic i_mode_select,
	input wire logic [7:0] i_input_data_lines,
	input wire logic [2:0] i_digit_address,
	input wire logic [1:0] i_format_shutdown_select,
	output logic [7:0] o_digit_strobe_outputs,
	output logic [7:0] o_segment_drive,
	output logic o_shutdown,
	output logic o_blanked
);
	import led_scan_pkg::*;

	typedef struct packed {
		logic wr_s1;
		logic wr_s2;
		logic wr_s3;
		logic mode_s1;
		logic mode_s2;
		logic [7:0] data_s1;
		logic [7:0] data_s2;
		logic [2:0] addr_s1;
		logic [2:0] addr_s2;
		logic [1:0] fss_s1;
		logic [1:0] fss_s2;
		logic hold_mode;
		logic [7:0] hold_data;
		logic [2:0] hold_addr;
		logic [7:0] ctrl;
		logic seq_active;
		logic [2:0] seq_cnt;
		logic locked;
		logic [15:0] presc;
		logic [15:0] ticks;
		scan_state_type state;
		logic [2:0] slot;
		logic [7:0] digit;
		logic [7:0] seg;
	} core_state_type;

	core_state_type r;
	core_state_type n;
	logic take;
	logic shut;
	logic decoded;
	logic bank_b;
	logic hex;
	logic tick;
	logic ram_we;
	logic [2:0] ram_wa;
	logic [RAM_W-1:0] ram_wd;
	logic [RAM_W-1:0] ram_wm;
	logic [RAM_W-1:0] ram_rd;
	logic [2:0] rd_digit;
	fmt_type fmt;
	logic [7:0] dec_seg;

	// write taken at the rising edge of the synchronised strobe
	assign take = r.wr_s2 && !r.wr_s3;
	assign shut = PARALLEL_VARIANT ? (r.fss_s2 == FSS_LOW)
		: !r.ctrl[CW_RUN];
	assign decoded = PARALLEL_VARIANT || r.ctrl[CW_DECODE];
	assign bank_b = !PARALLEL_VARIANT && r.ctrl[CW_BANK];
	assign hex = PARALLEL_VARIANT ? (r.fss_s2 == FSS_HIGH)
		: r.ctrl[CW_HEX];
	assign tick = (r.presc == 16'(TICK_LEN - 1));
	assign rd_digit = digit_of_slot(r.slot);

	// per word format: direct words only on the control variant
	always_comb
	begin
		if (ram_rd[RAM_RAW] && !PARALLEL_VARIANT)
		begin
			fmt = FMT_RAW;
		end
		else if (hex)
		begin
			fmt = FMT_HEX;
		end
		else
		begin
			fmt = FMT_CODEB;
		end
	end

	led_digit_ram #(
		.DEPTH(NUM_DIGITS),
		.WIDTH(RAM_W)
	) u_ram (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_wr_en(ram_we),
		.i_wr_addr(ram_wa),
		.i_wr_data(ram_wd),
		.i_wr_mask(ram_wm),
		.i_rd_addr(rd_digit),
		.o_rd_data(ram_rd)
	);

	led_seg_decode u_dec (
		.i_fmt(fmt),
		.i_code(bank_b ? ram_rd[7:4] : ram_rd[3:0]),
		.i_raw(ram_rd[7:0]),
		.i_dp(ram_rd[RAM_DP]),
		.o_seg(dec_seg)
	);

	always_comb
	begin
		n = r;
		ram_we = 1'b0;
		ram_wa = 3'h0;
		ram_wd = '0;
		ram_wm = '0;
		// pin synchronisers
		n.wr_s1 = i_write_n;
		n.wr_s2 = r.wr_s1;
		n.wr_s3 = r.wr_s2;
		n.mode_s1 = i_mode_select;
		n.mode_s2 = r.mode_s1;
		n.data_s1 = i_input_data_lines;
		n.data_s2 = r.data_s1;
		n.addr_s1 = i_digit_address;
		n.addr_s2 = r.addr_s1;
		n.fss_s1 = i_format_shutdown_select;
		n.fss_s2 = r.fss_s1;
		// inputs followed while the strobe is low, held while it is high
		if (!r.wr_s2)
		begin
			n.hold_mode = r.mode_s2;
			n.hold_data = r.data_s2;
			n.hold_addr = r.addr_s2;
		end
		// ram word built from the held data
		if (decoded)
		begin
			ram_wd = {1'b0, r.hold_data[DATA_DP], r.hold_data[3:0],
				r.hold_data[3:0]};
			ram_wm = bank_b ? MASK_BANK_B : MASK_BANK_A;
		end
		else
		begin
			ram_wd = {1'b1, 1'b0, r.hold_data};
			ram_wm = MASK_RAW;
		end
		// data entry, independent of shutdown
		if (take)
		begin
			if (PARALLEL_VARIANT)
			begin
				ram_we = 1'b1;
				ram_wa = r.hold_addr;
			end
			else if (r.hold_mode)
			begin
				n.ctrl = r.hold_data;
				n.seq_active = r.hold_data[CW_DATA_COMING];
				n.seq_cnt = 3'h0;
				n.locked = 1'b0;
			end
			else if (r.seq_active)
			begin
				ram_we = 1'b1;
				ram_wa = r.seq_cnt;
				n.seq_cnt = r.seq_cnt + 3'h1;
				if (r.seq_cnt == 3'(NUM_DIGITS - 1))
				begin
					n.seq_active = 1'b0;
					n.locked = 1'b1;
				end
			end
			else if (!r.locked)
			begin
				ram_we = 1'b1;
				ram_wa = r.ctrl[CW_ADDR_LSB +: 3];
			end
		end
		// multiplex scan
		if (shut)
		begin
			n.presc = 16'h0000;
			n.ticks = 16'h0000;
			n.state = SCAN_GAP;
			n.slot = 3'h0;
		end
		else
		begin
			n.presc = tick ? 16'h0000 : r.presc + 16'h0001;
			if (tick)
			begin
				n.ticks = r.ticks + 16'h0001;
				unique case (r.state)
					SCAN_GAP:
					begin
						if (r.ticks == 16'(GAP_LEN - 1))
						begin
							n.state = SCAN_ON;
							n.ticks = 16'h0000;
						end
					end
					SCAN_ON:
					begin
						if (r.ticks == 16'(ON_LEN - 1))
						begin
							n.state = SCAN_GAP;
							n.ticks = 16'h0000;
							n.slot = r.slot + 3'h1;
						end
					end
				endcase
			end
		end
		// drive only inside the on window of a running, unblanked scan
		if (n.state == SCAN_ON && !shut && !n.seq_active)
		begin
			n.digit = 8'h01 << digit_of_slot(n.slot);
			n.seg = dec_seg;
		end
		else
		begin
			n.digit = 8'h00;
			n.seg = 8'h00;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			r <= '0;
			r.wr_s1 <= 1'b1;
			r.wr_s2 <= 1'b1;
			r.wr_s3 <= 1'b1;
			r.ctrl <= CTRL_RESET;
		end
		else
		begin
			r <= n;
		end
	end

	assign o_digit_strobe_outputs = r.digit;
	assign o_segment_drive = r.seg;
	assign o_shutdown = shut;
	assign o_blanked = r.seq_active;

	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_n);

	AST_SHUT_DARK: assert property (shut |=> (r.digit == 8'h00)
		&& (r.seg == 8'h00))
		else $error("drive active after shutdown");
	AST_SHUT_HOLD: assert property (shut && $past(shut) |->
		r.state == SCAN_GAP && r.presc == 16'h0000)
		else $error("scan moving during shutdown");
	AST_ONE_DIGIT: assert property ($onehot0(r.digit))
		else $error("more than one digit driven");
	AST_GAP_DARK: assert property (r.state == SCAN_GAP |->
		r.digit == 8'h00 && r.seg == 8'h00)
		else $error("drive active in interdigit gap");
	AST_GAP_LEN: assert property (r.state == SCAN_GAP |->
		r.ticks < 16'(GAP_LEN))
		else $error("gap overran");
	AST_ON_LEN: assert property (r.state == SCAN_ON |->
		r.ticks < 16'(ON_LEN))
		else $error("digit on time overran");
	AST_SLOT_STEP: assert property (!shut && $changed(r.slot) |->
		r.slot == 3'($past(r.slot) + 3'h1)
		&& r.state == SCAN_GAP)
		else $error("scan slot skipped");
	AST_CTRL_LOAD: assert property (take && r.hold_mode
		&& !PARALLEL_VARIANT |=> r.ctrl == $past(r.hold_data))
		else $error("control word not loaded");
	AST_SEQ_BLANK: assert property (r.seq_active |->
		r.digit == 8'h00 ##1 (r.digit == 8'h00 || !r.seq_active))
		else $error("display lit during sequential update");
	AST_SEQ_DONE: assert property (take && !r.hold_mode && r.seq_active
		&& r.seq_cnt == 3'h7 && !PARALLEL_VARIANT |=>
		!r.seq_active && r.locked)
		else $error("sequential update did not end after eight");
	AST_DP_DECODED: assert property (fmt != FMT_RAW |->
		dec_seg[SEG_DP] == !ram_rd[RAM_DP])
		else $error("decimal point not from stored bit");
	AST_DP_RAW: assert property (fmt == FMT_RAW |->
		dec_seg[SEG_DP] == !ram_rd[DATA_DP])
		else $error("direct decimal point polarity wrong");

	COV_SEQ_DONE: cover property (r.seq_active ##1 !r.seq_active);
	COV_SHUTDOWN: cover property (!shut ##1 shut);
	COV_WRAP: cover property (r.slot == 3'h7 ##1 r.slot == 3'h0);
	COV_DIGIT_ON: cover property (r.state == SCAN_ON && r.digit != 8'h00);
endmodule

// File: test/led_host_model.sv
// host side model writing control words and display data
`timescale 1ns/1ns
module led_host_model (
	input wire logic i_clk_sys,
	output logic o_write_n,
	output logic o_mode_select,
	output logic [7:0] o_input_data_lines
);
	initial
	begin
		o_write_n = 1'b1;
		o_mode_select = 1'b0;
		o_input_data_lines = 8'h00;
	end
	// one strobe pulse, data held past the rise, then the bus is driven to the inverted data
	task automatic wr(input logic mode, input logic [7:0] data);
		@(negedge i_clk_sys);
		o_mode_select = mode;
		o_input_data_lines = data;
		o_write_n = 1'b0;
		repeat (4) @(negedge i_clk_sys);
		o_write_n = 1'b1;
		repeat (3) @(negedge i_clk_sys);
		o_input_data_lines = ~data;
		repeat (3) @(negedge i_clk_sys);
	endtask
endmodule

// File: test/led_scan_core_tb_top.sv
// self-checking bench for the led decode and scan core
`timescale 1ns/1ns
module led_scan_core_tb_top;
	import led_scan_pkg::*;
	localparam int TL = 2;
	localparam int GL = 2;
	localparam int OL = 4;
	logic clk, rst_n, wn, ms, shut, blk;
	logic [7:0] idl, strobes, segs, cw, v, acc;
	logic [2:0] dadr;
	logic [1:0] fss;
	int err_count = 0;
	int total_checks = 0;
	int seed = 23;
	int wa, nseq;
	logic [7:0] ram[8];
	bit raw[8];
	logic [3:0] rb[8];
	logic [7:0] pram[8];
	logic [7:0] st2, sg2, so, sg;
	logic sh2;
	bit par = 1'b0;
	int order[8] = '{1, 4, 0, 6, 7, 5, 3, 2};
	int ctab[7] = '{'hf0, 'hf0, 'hb0, 'hb0, 'h90, 'hb0, 'h90};
	logic [7:0] hexs[16] = '{8'h3f, 8'h06, 8'h5b, 8'h4f, 8'h66, 8'h6d,
		8'h7d, 8'h07, 8'h7f, 8'h6f, 8'h77, 8'h7c, 8'h39, 8'h5e, 8'h79, 8'h71};
	logic [7:0] cbs[6] = '{8'h40, 8'h79, 8'h76, 8'h38, 8'h73, 8'h00};

	led_host_model host_u (
		.i_clk_sys(clk),
		.o_write_n(wn),
		.o_mode_select(ms),
		.o_input_data_lines(idl)
	);

	led_scan_core #(.TICK_LEN(TL), .GAP_LEN(GL), .ON_LEN(OL)) dut_u (
		.i_clk_sys(clk),
		.i_rst_n(rst_n),
		.i_write_n(wn),
		.i_mode_select(ms),
		.i_input_data_lines(idl),
		.i_digit_address(dadr),
		.i_format_shutdown_select(fss),
		.o_digit_strobe_outputs(strobes),
		.o_segment_drive(segs),
		.o_shutdown(shut),
		.o_blanked(blk)
	);

	led_scan_core #(.PARALLEL_VARIANT(1'b1), .TICK_LEN(TL), .GAP_LEN(GL),
		.ON_LEN(OL)) par_u (
		.i_clk_sys(clk),
		.i_rst_n(rst_n),
		.i_write_n(wn),
		.i_mode_select(ms),
		.i_input_data_lines(idl),
		.i_digit_address(dadr),
		.i_format_shutdown_select(fss),
		.o_digit_strobe_outputs(st2),
		.o_segment_drive(sg2),
		.o_shutdown(sh2),
		.o_blanked()
	);

	assign so = par ? st2 : strobes;
	assign sg = par ? sg2 : segs;

	task automatic conclude();
		if (err_count == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	function automatic logic [7:0] exp_seg(int d);
		logic [7:0] w;
		logic [7:0] t;
		logic [3:0] c;
		logic hx;
		w = par ? pram[d] : ram[d];
		c = (!par && cw[3]) ? rb[d] : w[3:0];
		hx = par ? (fss == 2'h3) : cw[6];
		t = hexs[c];
		if (!hx && c > 4'h9)
			t = cbs[c - 4'ha];
		if (!par && raw[d])
			t = {1'b0, w[2], w[1], w[3], w[0], w[4], w[5], w[6]};
		return {~w[7], t[6:0]};
	endfunction

	task automatic wait_val(logic want);
		int n;
		n = 0;
		while (((so != 8'h00) !== want) && n < 400)
		begin
			@(negedge clk);
			n++;
		end
		if ((so != 8'h00) !== want)
		begin
			err_count++;
			conclude();
		end
	endtask

	// follows eight slots from the start of a lit digit
	task automatic scan();
		int pos, d, n;
		logic [7:0] s0, g0;
		wait_val(1'b0);
		wait_val(1'b1);
		pos = 0;
		for (int i = 0; i < 8; i++)
			if (so[order[i]] === 1'b1)
				pos = i;
		for (int s = 0; s < 8; s++)
		begin
			d = order[(pos + s) % 8];
			chk("strobe", so, 8'h01 << d);
			chk("segment", sg, exp_seg(d));
			s0 = so;
			g0 = sg;
			n = 0;
			while (so === s0 && sg === g0 && n < 400)
			begin
				@(negedge clk);
				n++;
			end
			chk("on length", 8'(n), 8'(OL * TL));
			n = 0;
			while (so === 8'h00 && sg === 8'h00 && n < 400)
			begin
				@(negedge clk);
				n++;
			end
			chk("gap length", 8'(n), 8'(GL * TL));
		end
	endtask

	task automatic ctl(logic [7:0] c);
		host_u.wr(1'b1, c);
		cw = c;
		wa = c[7] ? 0 : int'(c[2:0]);
		nseq = c[7] ? 8 : 0;
	endtask

	task automatic put(logic [7:0] w);
		dadr = 3'($random(seed));
		fss = 2'($random(seed));
		host_u.wr(1'b0, w);
		if (!cw[7] || nseq > 0)
		begin
			if (cw[5] && cw[3])
			begin
				ram[wa][7] = w[7];
				rb[wa] = w[3:0];
			end
			else
				ram[wa] = w;
			if (!cw[5])
				rb[wa] = w[7:4];
			raw[wa] = ~cw[5];
		end
		if (nseq > 0)
		begin
			nseq--;
			wa++;
		end
	endtask

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial
	begin
		rst_n = 1'b0;
		dadr = 3'h0;
		fss = 2'h0;
		cw = 8'h00;
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		chk("shutdown", {7'h00, shut}, 8'h01);
		for (int p = 0; p < 7; p++)
		begin
			ctl(8'(ctab[p]));
			chk("blanked", {7'h00, blk}, 8'h01);
			for (int k = 0; k < 8; k++)
			begin
				v = 8'($random(seed));
				if (p < 4)
					v = {v[7], 3'h0, 1'(p % 2), 3'(k)};
				if (p == 5)
					v = 8'hff;
				if (p == 6)
					v = 8'h80;
				put(v);
			end
			chk("blanked", {7'h00, blk}, 8'h00);
			put(8'h00);
			scan();
		end
		ctl(8'h23);
		chk("shutdown", {7'h00, shut}, 8'h01);
		acc = 8'h00;
		repeat (40)
		begin
			@(negedge clk);
			acc = acc | strobes | segs;
		end
		chk("dark", acc, 8'h00);
		put(8'h05);
		put(8'h8a);
		ctl(8'h73);
		chk("shutdown", {7'h00, shut}, 8'h00);
		scan();
		ctl(8'h7b);
		put(8'h06);
		scan();
		ctl(8'h73);
		scan();
		par = 1'b1;
		fss = 2'h0;
		for (int k = 0; k < 8; k++)
		begin
			v = 8'($random(seed));
			dadr = 3'(k);
			host_u.wr(1'b0, v);
			pram[k] = v;
		end
		chk("shutdown", {7'h00, sh2}, 8'h01);
		fss = 2'h3;
		scan();
		fss = 2'h1;
		scan();
		conclude();
	end
endmodule
